//--- design/timer_channel_pkg.sv
// constants and types shared by the timer counter and its channels
package timer_channel_pkg;
  // -------------------------------------------------------------
  // sizes
  // -------------------------------------------------------------
  localparam int NUM_CH = 2;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int PRESC_W = 7;
  localparam int SYNC_W = 3;

  // -------------------------------------------------------------
  // clock source codes
  // -------------------------------------------------------------
  localparam logic [1:0] CLK_NONE = 2'h0;
  localparam logic [1:0] CLK_BUS = 2'h1;
  localparam logic [1:0] CLK_FIXED = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;

  // -------------------------------------------------------------
  // channel mode codes (3 is treated as pwm)
  // -------------------------------------------------------------
  localparam logic [1:0] MODE_CAPTURE = 2'h0;
  localparam logic [1:0] MODE_COMPARE = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;

  // -------------------------------------------------------------
  // values
  // -------------------------------------------------------------
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_FREE_TOP = 16'hffff;
  localparam logic [15:0] MOD_FREE = 16'h0000;
  localparam logic [6:0] PRESC_RESET = 7'h00;
  localparam logic [6:0] PRESC_ONE = 7'h01;
  localparam logic [6:0] PRESC_ALL = 7'h7f;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} count_dir_t;

  // coherent read latch: which byte was read first
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_HIGH_FIRST = 2'b01,
    RD_LOW_FIRST = 2'b10
  } read_latch_t;

  typedef struct packed {
    read_latch_t st;
    logic [15:0] hold;
    logic [7:0] data;
  } read_view_t;
endpackage

//--- design/timer_channel_slice.sv
// one timer channel: write buffer, buffered load, capture and output
`timescale 1ns/1ns
module timer_channel_slice
  import timer_channel_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [1:0] mode_i,
  input wire logic centre_align_select_i,
  input wire logic clock_on_i,
  input wire logic count_tick_i,
  input wire logic pwm_load_i,
  input wire logic [15:0] counter_i,
  input wire logic [15:0] top_i,
  input wire logic high_wr_i,
  input wire logic low_wr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic capture_i,
  output logic [15:0] value_o,
  output logic out_o
);
  logic [7:0] buf_hi_reg, buf_hi_next;
  logic [7:0] buf_lo_reg, buf_lo_next;
  logic hi_done_reg, hi_done_next;
  logic lo_done_reg, lo_done_next;
  logic [15:0] value_reg, value_next;
  logic out_reg, out_next;
  logic is_capture, is_compare, is_pwm, load;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    is_capture = (mode_i == MODE_CAPTURE);
    is_compare = (mode_i == MODE_COMPARE);
    is_pwm = (mode_i >= MODE_PWM);
    buf_hi_next = buf_hi_reg;
    buf_lo_next = buf_lo_reg;
    hi_done_next = hi_done_reg;
    lo_done_next = lo_done_reg;
    value_next = value_reg;
    out_next = out_reg;
    // with no clock source the buffer loads as soon as both bytes are in
    load = hi_done_reg && lo_done_reg && !is_capture &&
           (!clock_on_i || (is_compare && count_tick_i) || (is_pwm && pwm_load_i));
    if (load) begin
      value_next = {buf_hi_reg, buf_lo_reg};
      hi_done_next = 1'b0;
      lo_done_next = 1'b0;
    end
    if (is_capture) begin
      if (capture_i) begin
        value_next = counter_i;
      end
      hi_done_next = 1'b0;
      lo_done_next = 1'b0;
    end else begin
      if (high_wr_i) begin
        buf_hi_next = wr_data_i;
        hi_done_next = 1'b1;
      end
      if (low_wr_i) begin
        buf_lo_next = wr_data_i;
        lo_done_next = 1'b1;
      end
    end
    if (is_pwm) begin
      if (centre_align_select_i && value_reg == top_i) begin
        out_next = 1'b1;
      end else begin
        out_next = (counter_i < value_reg);
      end
    end else if (is_compare) begin
      if (count_tick_i && counter_i == value_reg) begin
        out_next = ~out_reg;
      end
    end else begin
      out_next = 1'b0;
    end
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      buf_hi_reg <= BYTE_RESET;
      buf_lo_reg <= BYTE_RESET;
      hi_done_reg <= 1'b0;
      lo_done_reg <= 1'b0;
      value_reg <= CNT_RESET;
      out_reg <= 1'b0;
    end else begin
      buf_hi_reg <= buf_hi_next;
      buf_lo_reg <= buf_lo_next;
      hi_done_reg <= hi_done_next;
      lo_done_reg <= lo_done_next;
      value_reg <= value_next;
      out_reg <= out_next;
    end
  end

  assign value_o = value_reg;
  assign out_o = out_reg;
endmodule

//--- design/timer_channel_update_rules.sv
// timer counter with prescaler, coherent byte reads and buffered channels
`timescale 1ns/1ns
module timer_channel_update_rules
  import timer_channel_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic background_debug_mode_i,
  input wire logic [1:0] clock_source_select_i,
  input wire logic [2:0] prescale_select_i,
  input wire logic centre_align_select_i,
  input wire logic [15:0] modulo_value_i,
  input wire logic fixed_clk_tick_i,
  input wire logic ext_clk_i,
  input wire logic [7:0] wr_data_i,
  input wire logic timer_status_control_wr_i,
  input wire logic counter_high_byte_wr_i,
  input wire logic counter_low_byte_wr_i,
  input wire logic counter_high_byte_rd_i,
  input wire logic counter_low_byte_rd_i,
  input wire logic [NUM_CH-1:0][1:0] channel_mode_i,
  input wire logic [NUM_CH-1:0] channel_status_control_wr_i,
  input wire logic [NUM_CH-1:0] channel_value_high_wr_i,
  input wire logic [NUM_CH-1:0] channel_value_low_wr_i,
  input wire logic [NUM_CH-1:0] channel_value_high_rd_i,
  input wire logic [NUM_CH-1:0] channel_value_low_rd_i,
  input wire logic [NUM_CH-1:0] capture_i,
  output logic [7:0] counter_rd_data_o,
  output logic [NUM_CH-1:0][7:0] channel_rd_data_o,
  output logic [15:0] counter_o,
  output logic [NUM_CH-1:0][15:0] channel_value_o,
  output logic [NUM_CH-1:0] channel_out_o
);
  // -------------------------------------------------------------
  // coherent byte read view
  // -------------------------------------------------------------
  function automatic read_view_t read_step(
    input read_view_t cur,
    input logic [15:0] live,
    input logic rd_hi,
    input logic rd_lo,
    input logic dbg,
    input logic clr
  );
    read_view_t r;
    read_latch_t st;
    r = cur;
    // a restart and a read in one cycle: the read starts from an idle latch
    st = clr ? RD_IDLE : cur.st;
    r.st = st;
    if (dbg) begin
      if (rd_hi) begin
        r.data = live[15:8];
      end else if (rd_lo) begin
        r.data = live[7:0];
      end
    end else if (rd_hi) begin
      case (st)
        RD_IDLE: begin
          r.hold = live;
          r.data = live[15:8];
          r.st = RD_HIGH_FIRST;
        end
        RD_HIGH_FIRST: begin
          r.data = cur.hold[15:8];
        end
        RD_LOW_FIRST: begin
          r.data = cur.hold[15:8];
          r.st = RD_IDLE;
        end
        default: begin
          r.st = RD_IDLE;
        end
      endcase
    end else if (rd_lo) begin
      case (st)
        RD_IDLE: begin
          r.hold = live;
          r.data = live[7:0];
          r.st = RD_LOW_FIRST;
        end
        RD_LOW_FIRST: begin
          r.data = cur.hold[7:0];
        end
        RD_HIGH_FIRST: begin
          r.data = cur.hold[7:0];
          r.st = RD_IDLE;
        end
        default: begin
          r.st = RD_IDLE;
        end
      endcase
    end
    return r;
  endfunction

  // -------------------------------------------------------------
  // external clock synchroniser
  // -------------------------------------------------------------
  logic [2:0] ext_sync_reg, ext_sync_next;
  logic ext_level_reg, ext_level_next;
  logic ext_tick;

  always_comb begin
    ext_sync_next = {ext_sync_reg[1:0], ext_clk_i};
    ext_level_next = ext_level_reg;
    if (ext_sync_reg[1] == ext_sync_reg[2]) begin
      ext_level_next = ext_sync_reg[2];
    end
    ext_tick = ext_level_next & ~ext_level_reg;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_sync_reg <= SYNC_RESET;
      ext_level_reg <= 1'b0;
    end else begin
      ext_sync_reg <= ext_sync_next;
      ext_level_reg <= ext_level_next;
    end
  end

  // -------------------------------------------------------------
  // counter and prescaler
  // -------------------------------------------------------------
  logic [15:0] counter_reg, counter_next;
  logic [6:0] presc_reg, presc_next;
  count_dir_t dir_reg, dir_next;
  logic [15:0] top;
  logic [6:0] presc_limit;
  logic clock_on, src_tick, run, cnt_tick, pwm_load, cnt_wr;

  // source tick, terminal count and prescale limit
  always_comb begin
    if (modulo_value_i == MOD_FREE) begin
      top = CNT_FREE_TOP;
    end else begin
      top = modulo_value_i;
    end
    clock_on = (clock_source_select_i != CLK_NONE);
    case (clock_source_select_i)
      CLK_BUS: begin
        src_tick = 1'b1;
      end
      CLK_FIXED: begin
        src_tick = fixed_clk_tick_i;
      end
      CLK_EXT: begin
        src_tick = ext_tick;
      end
      default: begin
        src_tick = 1'b0;
      end
    endcase
    presc_limit = ~(PRESC_ALL << prescale_select_i);
  end

  always_comb begin
    run = clock_on && src_tick && !background_debug_mode_i;
    cnt_tick = run && (presc_reg == presc_limit);
    pwm_load = cnt_tick && (dir_reg == DIR_UP) && (counter_reg == top - CNT_ONE);
    cnt_wr = counter_high_byte_wr_i | counter_low_byte_wr_i;
    counter_next = counter_reg;
    presc_next = presc_reg;
    dir_next = dir_reg;
    if (run) begin
      if (cnt_tick) begin
        presc_next = PRESC_RESET;
      end else begin
        presc_next = presc_reg + PRESC_ONE;
      end
    end
    if (cnt_tick) begin
      if (!centre_align_select_i) begin
        dir_next = DIR_UP;
        if (counter_reg >= top) begin
          counter_next = CNT_RESET;
        end else begin
          counter_next = counter_reg + CNT_ONE;
        end
      end else begin
        case (dir_reg)
          DIR_UP: begin
            if (counter_reg >= top) begin
              dir_next = DIR_DOWN;
              counter_next = counter_reg - CNT_ONE;
            end else begin
              counter_next = counter_reg + CNT_ONE;
            end
          end
          DIR_DOWN: begin
            if (counter_reg == CNT_RESET) begin
              dir_next = DIR_UP;
              counter_next = counter_reg + CNT_ONE;
            end else begin
              counter_next = counter_reg - CNT_ONE;
            end
          end
          default: begin
            dir_next = DIR_UP;
          end
        endcase
      end
    end
    if (cnt_wr) begin
      counter_next = CNT_RESET;
      presc_next = PRESC_RESET;
      dir_next = DIR_UP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      counter_reg <= CNT_RESET;
      presc_reg <= PRESC_RESET;
      dir_reg <= DIR_UP;
    end else begin
      counter_reg <= counter_next;
      presc_reg <= presc_next;
      dir_reg <= dir_next;
    end
  end

  assign counter_o = counter_reg;

  // -------------------------------------------------------------
  // counter read latch
  // -------------------------------------------------------------
  read_view_t cnt_view_reg, cnt_view_next;

  always_comb begin
    cnt_view_next = read_step(cnt_view_reg, counter_reg, counter_high_byte_rd_i,
                              counter_low_byte_rd_i, background_debug_mode_i,
                              timer_status_control_wr_i | cnt_wr);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_view_reg <= '{st: RD_IDLE, hold: CNT_RESET, data: BYTE_RESET};
    end else begin
      cnt_view_reg <= cnt_view_next;
    end
  end

  assign counter_rd_data_o = cnt_view_reg.data;

  // -------------------------------------------------------------
  // channels
  // -------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [15:0] value;
    read_view_t view_reg, view_next;

    timer_channel_slice u_slice (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .mode_i(channel_mode_i[ch]),
      .centre_align_select_i(centre_align_select_i),
      .clock_on_i(clock_on),
      .count_tick_i(cnt_tick),
      .pwm_load_i(pwm_load),
      .counter_i(counter_reg),
      .top_i(top),
      .high_wr_i(channel_value_high_wr_i[ch]),
      .low_wr_i(channel_value_low_wr_i[ch]),
      .wr_data_i(wr_data_i),
      .capture_i(capture_i[ch]),
      .value_o(value),
      .out_o(channel_out_o[ch])
    );

    always_comb begin
      view_next = read_step(view_reg, value, channel_value_high_rd_i[ch],
                            channel_value_low_rd_i[ch], background_debug_mode_i,
                            channel_status_control_wr_i[ch]);
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        view_reg <= '{st: RD_IDLE, hold: CNT_RESET, data: BYTE_RESET};
      end else begin
        view_reg <= view_next;
      end
    end

    assign channel_rd_data_o[ch] = view_reg.data;
    assign channel_value_o[ch] = value;
  end
endmodule

//--- verification/timer_channel_update_rules_checker.sv
// assertion checker for the timer counter and channel update behaviour
`timescale 1ns/1ns
module timer_channel_update_rules_checker
  import timer_channel_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic background_debug_mode_i,
  input wire logic [1:0] clock_source_select_i,
  input wire logic centre_align_select_i,
  input wire logic [15:0] modulo_value_i,
  input wire logic counter_high_byte_wr_i,
  input wire logic counter_low_byte_wr_i,
  input wire logic counter_high_byte_rd_i,
  input wire logic [NUM_CH-1:0][1:0] channel_mode_i,
  input wire logic [NUM_CH-1:0] capture_i,
  input wire logic [7:0] counter_rd_data_o,
  input wire logic [15:0] counter_o,
  input wire logic [NUM_CH-1:0][15:0] channel_value_o,
  input wire logic [NUM_CH-1:0] channel_out_o
);
  // ------------------------------
  // helpers
  // ------------------------------
  logic cnt_wr;
  logic clk_on;
  logic cmp0;
  logic pwm1;
  logic full1;
  logic [7:0] cnt_hi;
  logic [15:0] top;
  assign cnt_wr = counter_high_byte_wr_i | counter_low_byte_wr_i;
  assign clk_on = clock_source_select_i != CLK_NONE;
  assign cmp0 = channel_mode_i[0] == MODE_COMPARE;
  assign pwm1 = channel_mode_i[1][1];
  assign cnt_hi = counter_o[15:8];
  assign top = (modulo_value_i == MOD_FREE) ? CNT_FREE_TOP : modulo_value_i;
  assign full1 = centre_align_select_i & pwm1 & (channel_value_o[1] == top) &
                 (top != CNT_FREE_TOP);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // ------------------------------
  // assertions
  // ------------------------------
  cnt_clear_a: assert property (cnt_wr |=> counter_o == CNT_RESET)
    else $error("counter not cleared by write");
  dbg_freeze_a: assert property (background_debug_mode_i && !cnt_wr
    |=> $stable(counter_o)) else $error("counter moved in debug");
  dbg_read_a: assert property (background_debug_mode_i && counter_high_byte_rd_i
    && !cnt_wr |=> counter_rd_data_o == $past(cnt_hi)) else $error("debug read not live");
  cap_ignore_a: assert property (channel_mode_i[0] == MODE_CAPTURE && !capture_i[0]
    |=> $stable(channel_value_o[0])) else $error("capture value overwritten");
  cmp_load_a: assert property ($changed(channel_value_o[0]) && $past(cmp0) && $past(clk_on)
    |-> $changed(counter_o)) else $error("compare load off counter step");
  pwm_load_a: assert property ($changed(channel_value_o[1]) && $past(pwm1)
    && $past(clk_on) |-> counter_o == $past(top)) else $error("pwm load off top step");
  full_duty_a: assert property (full1 [*2] |-> channel_out_o[1])
    else $error("centre pwm not full duty");
  stop_count_a: assert property (!clk_on && !cnt_wr |=> $stable(counter_o))
    else $error("counter moved with no clock");
  wr_c: cover property (cnt_wr);
  dbg_c: cover property (background_debug_mode_i && counter_high_byte_rd_i);
  load_c: cover property ($changed(channel_value_o[1]) && pwm1);
endmodule

bind timer_channel_update_rules timer_channel_update_rules_checker u_checker (.*);

//--- verification/tb_timer_channel_update_rules.sv
// self-checking bench for the timer counter and channel update behaviour
`timescale 1ns/1ns
module tb_timer_channel_update_rules
  import timer_channel_pkg::*;
;
  logic clk_i, srst_i, background_debug_mode_i, centre_align_select_i;
  logic fixed_clk_tick_i, ext_clk_i, timer_status_control_wr_i;
  logic counter_high_byte_wr_i, counter_low_byte_wr_i;
  logic counter_high_byte_rd_i, counter_low_byte_rd_i;
  logic [1:0] clock_source_select_i;
  logic [2:0] prescale_select_i;
  logic [15:0] modulo_value_i, counter_o, cnt_m, v;
  logic [7:0] wr_data_i, counter_rd_data_o;
  logic [NUM_CH-1:0][1:0] channel_mode_i;
  logic [NUM_CH-1:0] channel_status_control_wr_i, channel_value_high_wr_i;
  logic [NUM_CH-1:0] channel_value_low_wr_i, channel_value_high_rd_i;
  logic [NUM_CH-1:0] channel_value_low_rd_i, capture_i, channel_out_o;
  logic [NUM_CH-1:0][7:0] channel_rd_data_o;
  logic [NUM_CH-1:0][15:0] channel_value_o;
  logic [15:0] chv [NUM_CH];
  logic [9:0] expq [$];
  logic pend;
  int error_cnt, total_checks, cycles, seed;

  timer_channel_update_rules u_dut (.*);

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ------------------------------
  // checking and closing
  // ------------------------------
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // read data appears one cycle after the strobe edge
  always @(negedge clk_i) begin
    logic [9:0] e;
    if (pend) begin
      e = expq.pop_front();
      if (e[9:8] == 2'h0) check("counter_rd_data_o", 16'(counter_rd_data_o), 16'(e[7:0]));
      else check("channel_rd_data_o", 16'(channel_rd_data_o[e[9]]), 16'(e[7:0]));
    end
    pend = counter_high_byte_rd_i | counter_low_byte_rd_i;
    pend = pend | (|channel_value_high_rd_i) | (|channel_value_low_rd_i);
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ------------------------------
  // drivers
  // ------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic pulse(input int k, input int ch, input logic [7:0] d);
    wr_data_i = d;
    case (k)
      0: counter_high_byte_rd_i = 1'b1;
      1: counter_low_byte_rd_i = 1'b1;
      2: counter_low_byte_wr_i = 1'b1;
      9: counter_high_byte_wr_i = 1'b1;
      3: timer_status_control_wr_i = 1'b1;
      4: channel_value_high_rd_i[ch] = 1'b1;
      5: channel_value_low_rd_i[ch] = 1'b1;
      6: channel_value_high_wr_i[ch] = 1'b1;
      7: channel_value_low_wr_i[ch] = 1'b1;
      default: channel_status_control_wr_i[ch] = 1'b1;
    endcase
    step(1);
    {counter_high_byte_rd_i, counter_low_byte_rd_i, counter_low_byte_wr_i} = 3'h0;
    counter_high_byte_wr_i = 1'b0;
    {timer_status_control_wr_i, channel_value_high_rd_i, channel_value_low_rd_i} = 5'h00;
    {channel_value_high_wr_i, channel_value_low_wr_i, channel_status_control_wr_i} = 6'h00;
    step(1);
  endtask

  task automatic rd(input int k, input int ch, input logic [7:0] e);
    expq.push_back({(k < 4) ? 2'h0 : 2'(ch + 1), e});
    pulse(k, ch, 8'h00);
  endtask

  task automatic pair(input int ch, input logic [15:0] e);
    rd((ch < 0) ? 0 : 4, ch, e[15:8]);
    rd((ch < 0) ? 1 : 5, ch, e[7:0]);
  endtask

  task automatic wrv(input int ch, input logic [15:0] d);
    pulse(6, ch, d[15:8]);
    pulse(7, ch, d[7:0]);
  endtask

  task automatic run(input int n, input logic [1:0] src);
    clock_source_select_i = src;
    for (int i = 0; i < n; i++) begin
      fixed_clk_tick_i = i[0];
      ext_clk_i = i[3] && (i < n - 8);
      step(1);
    end
    {clock_source_select_i, fixed_clk_tick_i, ext_clk_i} = 4'h0;
    cnt_m = cnt_m + 16'((src == CLK_BUS) ? n : (src == CLK_FIXED) ? n / 2 : n / 16);
  endtask

  task automatic chan_load(input int ch, input logic [15:0] d, input int w);
    clock_source_select_i = CLK_BUS;
    pulse(9, 0, 8'h00);
    wrv(ch, d);
    pair(ch, chv[ch]);
    step(w);
    pair(ch, d);
    chv[ch] = d;
    clock_source_select_i = CLK_NONE;
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    seed = 32'he55fdccb;
    {background_debug_mode_i, centre_align_select_i, fixed_clk_tick_i, ext_clk_i} = 4'h0;
    {timer_status_control_wr_i, counter_high_byte_wr_i, counter_low_byte_wr_i} = 3'h0;
    {counter_high_byte_rd_i, counter_low_byte_rd_i, capture_i, wr_data_i} = 12'h000;
    {channel_status_control_wr_i, channel_value_high_wr_i, channel_value_low_wr_i} = 6'h00;
    {channel_value_high_rd_i, channel_value_low_rd_i, channel_mode_i} = 8'h00;
    {clock_source_select_i, prescale_select_i, modulo_value_i} = 21'h000000;
    {cnt_m, chv[0], chv[1], pend} = 49'h0;
    srst_i = 1'b1;
    step(16);
    srst_i = 1'b0;
    step(1);
    run(300, CLK_BUS);
    step(20);
    rd(1, 0, cnt_m[7:0]);
    rd(0, 0, cnt_m[15:8]);
    run(300, CLK_BUS);
    rd(1, 0, cnt_m[7:0]);
    v = cnt_m;
    run(300, CLK_BUS);
    rd(0, 0, v[15:8]);
    pair(-1, cnt_m);
    run(40, CLK_FIXED);
    run(72, CLK_EXT);
    pair(-1, cnt_m);
    $display("done counting and coherent reads");
    prescale_select_i = 3'h2;
    run(6, CLK_BUS);
    pulse(2, 0, 8'($random(seed)));
    check("counter_o", counter_o, 16'h0000);
    run(40, CLK_BUS);
    cnt_m = 16'h000a;
    pair(-1, cnt_m);
    prescale_select_i = 3'h0;
    $display("done counter write");
    rd(0, 0, cnt_m[15:8]);
    run(300, CLK_BUS);
    background_debug_mode_i = 1'b1;
    run(50, CLK_BUS);
    cnt_m = cnt_m - 16'd50;
    rd(1, 0, cnt_m[7:0]);
    rd(0, 0, cnt_m[15:8]);
    pulse(3, 0, 8'h00);
    background_debug_mode_i = 1'b0;
    pair(-1, cnt_m);
    $display("done counter debug");
    channel_mode_i = 4'h5;
    v = 16'($random(seed));
    wrv(0, v);
    rd(4, 0, v[15:8]);
    v = v ^ 16'h0f0f;
    wrv(0, v);
    background_debug_mode_i = 1'b1;
    rd(5, 0, v[7:0]);
    pulse(8, 0, 8'h00);
    background_debug_mode_i = 1'b0;
    rd(5, 0, v[7:0]);
    rd(4, 0, v[15:8]);
    channel_mode_i = 4'h4;
    wrv(0, ~v);
    pair(0, v);
    capture_i = 2'h1;
    step(1);
    capture_i = 2'h0;
    step(1);
    chv[0] = cnt_m;
    pair(0, cnt_m);
    $display("done channel debug and capture");
    channel_mode_i = 4'h5;
    prescale_select_i = 3'h7;
    chan_load(0, 16'($random(seed)), 140);
    prescale_select_i = 3'h0;
    modulo_value_i = 16'h0010;
    channel_mode_i = 4'h9;
    chan_load(1, 16'($random(seed)), 30);
    centre_align_select_i = 1'b1;
    channel_mode_i = 4'hd;
    chan_load(1, 16'h0010, 30);
    clock_source_select_i = CLK_BUS;
    for (int i = 0; i < 40; i++) begin
      check("channel_out_o", 16'(channel_out_o[1]), 16'h0001);
      step(1);
    end
    centre_align_select_i = 1'b0;
    modulo_value_i = 16'h0000;
    channel_mode_i = 4'h9;
    chan_load(1, 16'($random(seed)), 65540);
    $display("done buffered loads");
    step(5);
    end_of_test();
  end
endmodule
